// >>> include/tsc_pkg.sv
// Constants, field layout and timing for the switch control register block
// How it works
// - Writing bit 15 resets the whole device like the reset pin.
// - Bit 14 routes every receive stream straight to its transmit stream.
// - Bit 13 sets which indication pin level means stream driven.
// - Indication mode is chosen per stream group by the rate setting.
// - Bit 12 makes every transmit pin carry an enable indication.
// - Bit 11 high holds the pattern transmitter in its initial state.
// - Rising edge of bit 10 clears the error count register.
// - Rising edge of bit 9 starts the bit error test.
// - Bit 8 programs whole connection memory, ignoring start and end addresses.
// - Bits 7-5 give the mode value written to each high word.
// - Rising edge of bit 4 starts block programming, fast as processor writes.
// - Device clears bit 4 itself when block programming ends.
// - Host writing zero to bit 4 while running aborts programming.
// - Bit 3 zeroes bits 14-0 of each targeted low word.
// - Transmit drivers float only when drive pin and bit 2 are both zero.
// - Bits 1-0 pick memory behind processor window; 11 reserved.
// - Accesses with top address bit set go to the selected memory.
// - Full block programming finishes within two frames.
package tsc_pkg;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_BYPASS = 14;
  localparam int BIT_IND_POL = 13;
  localparam int BIT_ALL_IND = 12;
  localparam int BIT_PAT_RESET = 11;
  localparam int BIT_CLR_ERR = 10;
  localparam int BIT_START_TEST = 9;
  localparam int BIT_FULL_BLOCK = 8;
  localparam int BPV_HI = 7;
  localparam int BPV_LO = 5;
  localparam int BIT_BLOCK_EN = 4;
  localparam int BIT_CLR_LOW = 3;
  localparam int BIT_STANDBY = 2;
  localparam int MSEL_HI = 1;
  localparam int MSEL_LO = 0;
  // Address decode: control register sits at 0x0000-0x01ff, window at 0x8000-0xffff
  localparam int ADDR_W = 16;
  localparam int WIN_BIT = 15;
  localparam logic [6:0] CTRL_PAGE = 7'h00;
  localparam int PAGE_HI = 15;
  localparam int PAGE_LO = 9;
  // Memory select codes
  localparam logic [1:0] MSEL_CML = 2'h0;
  localparam logic [1:0] MSEL_CMH = 2'h1;
  localparam logic [1:0] MSEL_DM = 2'h2;
  // Block address register fields
  localparam int GRP_HI = 14;
  localparam int GRP_LO = 12;
  localparam int STR_HI = 11;
  localparam int STR_LO = 9;
  localparam int CH_HI = 8;
  localparam int CH_LO = 0;
  localparam int CH_W = 9;
  localparam int STR_W = 3;
  localparam int GRP_W = 3;
  localparam int BPV_W = 3;
  // Frame timing for the full block budget
  localparam int CLK_NS = 100;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
  localparam int FULL_BUDGET_CYCLES = 2 * FRAME_CYCLES;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b01,
    TSC_RUN = 2'b10
  } tsc_blk_state_type;
endpackage : tsc_pkg

// >>> include/tsc_blk_if.sv
// Link between the control register and the block programming walker
`timescale 1ns/10ps
interface tsc_blk_if;
  import tsc_pkg::*;
  logic clr;
  logic start;
  logic abort;
  logic full;
  logic [ADDR_W-1:0] start_addr;
  logic [ADDR_W-1:0] end_addr;
  logic busy;
  logic done;
  logic wr;
  logic all_streams;
  logic [GRP_W+STR_W-1:0] stream;
  logic [CH_W-1:0] channel;
  modport ctl (output clr, start, abort, full, start_addr, end_addr,
               input busy, done, wr, all_streams, stream, channel);
  modport eng (input clr, start, abort, full, start_addr, end_addr,
               output busy, done, wr, all_streams, stream, channel);
endinterface : tsc_blk_if

// >>> logic/tsc_block_walker.sv
// Connection memory block programming address walker
`timescale 1ns/10ps
module tsc_block_walker
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control side
  tsc_blk_if.eng bi
);
  import tsc_pkg::*;

  tsc_blk_state_type state_r;
  tsc_blk_state_type state_nxt;
  logic [CH_W-1:0] ch_r;
  logic [STR_W-1:0] st_r;
  logic [GRP_W-1:0] grp_r;
  logic [STR_W-1:0] st_first;
  logic [STR_W-1:0] st_last;
  logic [CH_W-1:0] ch_last;
  logic row_end;
  logic walk_end;

  ////////////////////////////////////////////////////////////////////////
  // Range decode; streams and channels wrap independently past the end
  assign st_first = bi.start_addr[STR_HI:STR_LO];
  assign st_last = bi.end_addr[STR_HI:STR_LO];
  assign ch_last = bi.full ? {CH_W{1'b1}} : bi.end_addr[CH_HI:CH_LO];
  // Full mode writes a whole channel row per cycle so 512 cycles suffice
  assign row_end = bi.full || (st_r == st_last);
  assign walk_end = row_end && (ch_r == ch_last);
  assign bi.busy = (state_r == TSC_RUN);
  assign bi.wr = bi.busy && !bi.abort;
  assign bi.all_streams = bi.full;
  assign bi.stream = {grp_r, st_r};
  assign bi.channel = ch_r;
  assign bi.done = bi.wr && walk_end;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TSC_IDLE: if (bi.start) state_nxt = TSC_RUN;
      TSC_RUN: if (bi.abort || walk_end) state_nxt = TSC_IDLE;
      default: state_nxt = TSC_IDLE;
    endcase
  end

  // State and address counters, one location or row per clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= TSC_IDLE;
      ch_r <= '0;
      st_r <= '0;
      grp_r <= '0;
    end
    else if (bi.clr)
    begin
      state_r <= TSC_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == TSC_IDLE)
      begin
        ch_r <= bi.full ? '0 : bi.start_addr[CH_HI:CH_LO];
        st_r <= st_first;
        grp_r <= bi.start_addr[GRP_HI:GRP_LO];
      end
      else if (row_end)
      begin
        st_r <= st_first;
        ch_r <= ch_r + 1'b1;
      end
      else
        st_r <= st_r + 1'b1;
    end
  end
endmodule : tsc_block_walker

// >>> logic/tsc_switch_control.sv
// Switch control register with host decode, window steering and output control
`timescale 1ns/10ps
module tsc_switch_control
#(
  parameter int NUM_STREAMS = 64,
  parameter int NUM_GROUPS = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host parallel bus, synchronous to clk
  input wire logic [tsc_pkg::ADDR_W-1:0] host_addr,
  input wire logic [tsc_pkg::CTRL_W-1:0] host_data_in,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [tsc_pkg::CTRL_W-1:0] host_data_out,
  output logic host_data_oe_n,
  // Processor window to internal memories
  output logic mem_wr,
  output logic mem_rd,
  output logic [tsc_pkg::ADDR_W-2:0] mem_addr,
  output logic [tsc_pkg::CTRL_W-1:0] mem_wdata,
  output logic cm_low_sel,
  output logic cm_high_sel,
  output logic dm_sel,
  input wire logic [tsc_pkg::CTRL_W-1:0] mem_rdata_cml,
  input wire logic [tsc_pkg::CTRL_W-1:0] mem_rdata_cmh,
  input wire logic [tsc_pkg::CTRL_W-1:0] mem_rdata_dm,
  // Block programming range and write port
  input wire logic [tsc_pkg::ADDR_W-1:0] block_start_address,
  input wire logic [tsc_pkg::ADDR_W-1:0] block_end_address,
  output logic blk_wr,
  output logic blk_all_streams,
  output logic [tsc_pkg::GRP_W+tsc_pkg::STR_W-1:0] blk_stream,
  output logic [tsc_pkg::CH_W-1:0] blk_channel,
  output logic [tsc_pkg::BPV_W-1:0] blk_channel_mode_bits,
  output logic blk_clear_low_word,
  // Bit error test controls
  output logic pattern_generator_reset,
  output logic clear_error_count,
  output logic start_error_test,
  // Device wide reset from software
  output logic device_reset,
  // Stream datapath and output control
  input wire logic output_drive_pin,
  input wire logic [NUM_GROUPS-1:0] data_rate_select,
  input wire logic [NUM_STREAMS-1:0] rx_data,
  input wire logic [NUM_STREAMS-1:0] switched_data,
  output logic [NUM_STREAMS-1:0] tx_out,
  output logic [NUM_STREAMS-1:0] tx_oe_n,
  output logic [NUM_GROUPS-1:0] enable_indication_pin,
  output logic rx_tx_bypass_bit
);
  import tsc_pkg::*;

  tsc_blk_if bi ();

  // Register state
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [CTRL_W-1:0] ctrl_prev_r;
  logic soft_reset_r;

  // Host read path
  logic [CTRL_W-1:0] rdata_r;
  logic rd_oe_r;

  // Pin synchronisers
  logic ode_meta_r;
  logic ode_sync_r;
  logic [NUM_STREAMS-1:0] rx_meta_r;
  logic [NUM_STREAMS-1:0] rx_sync_r;

  // Output stage
  logic [NUM_STREAMS-1:0] tx_r;
  logic [NUM_STREAMS-1:0] tx_oe_n_r;
  logic [NUM_GROUPS-1:0] ind_r;

  // Test pulses
  logic clr_err_r;
  logic start_test_r;

  // Host decode
  logic ctrl_hit;
  logic win_hit;
  logic ctrl_wr;
  logic ctrl_rd;
  logic win_rd;

  // Window steering
  logic [1:0] msel;
  logic sel_cml;
  logic sel_cmh;
  logic sel_dm;
  logic [CTRL_W-1:0] win_rdata;

  // Edge events
  logic bpe_rise;
  logic bpe_host_clear;
  logic clr_err_rise;
  logic start_test_rise;

  // Output control
  logic drive_on;
  logic ind_level;
  logic [NUM_STREAMS-1:0] tx_data_sel;
  logic [NUM_STREAMS-1:0] tx_mux;

  ////////////////////////////////////////////////////////////////////////
  // Host address decode
  assign win_hit = host_cs && host_addr[WIN_BIT];
  assign ctrl_hit = host_cs && (host_addr[PAGE_HI:PAGE_LO] == CTRL_PAGE);
  assign ctrl_wr = ctrl_hit && host_wr;
  assign ctrl_rd = ctrl_hit && host_rd;
  assign win_rd = win_hit && host_rd;

  // Memory window steering follows the select field as it stands now
  assign msel = ctrl_r[MSEL_HI:MSEL_LO];
  assign sel_cml = win_hit && (msel == MSEL_CML);
  assign sel_cmh = win_hit && (msel == MSEL_CMH);
  assign sel_dm = win_hit && (msel == MSEL_DM);
  assign cm_low_sel = sel_cml;
  assign cm_high_sel = sel_cmh;
  assign dm_sel = sel_dm;
  // Reserved code selects nothing: writes vanish and reads return zero
  assign mem_wr = (sel_cml || sel_cmh || sel_dm) && host_wr;
  assign mem_rd = (sel_cml || sel_cmh || sel_dm) && host_rd;
  assign mem_addr = host_addr[WIN_BIT-1:0];
  assign mem_wdata = host_data_in;
  assign win_rdata = sel_cml ? mem_rdata_cml :
                     sel_cmh ? mem_rdata_cmh :
                     sel_dm ? mem_rdata_dm : '0;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection against the previously held bit values
  // Start compares against the bit as held now, so a restart right after
  // completion or abort is not swallowed by the one-cycle-old copy
  assign bpe_rise = ctrl_nxt[BIT_BLOCK_EN] && !ctrl_r[BIT_BLOCK_EN];
  assign clr_err_rise = ctrl_r[BIT_CLR_ERR] && !ctrl_prev_r[BIT_CLR_ERR];
  assign start_test_rise = ctrl_r[BIT_START_TEST] && !ctrl_prev_r[BIT_START_TEST];
  assign bpe_host_clear = ctrl_wr && !host_data_in[BIT_BLOCK_EN] && bi.busy;

  // Register next value: device completion clear, then host write.
  // A host write landing with completion wins; bit 4 written high stays set but starts no new walk.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (bi.done)
    begin
      // Completion drops the enable and the block value together
      ctrl_nxt[BIT_BLOCK_EN] = 1'b0;
      ctrl_nxt[BPV_HI:BPV_LO] = '0;
    end
    if (ctrl_wr)
    begin
      ctrl_nxt = host_data_in;
      // Bit 15 never sticks; the reset is carried by soft_reset_r instead
      ctrl_nxt[BIT_SOFT_RESET] = 1'b0;
    end
  end

  // Control register; soft reset returns it and the device to reset state
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= CTRL_RESET;
      ctrl_prev_r <= CTRL_RESET;
      soft_reset_r <= 1'b0;
    end
    else if (soft_reset_r)
    begin
      ctrl_r <= CTRL_RESET;
      ctrl_prev_r <= CTRL_RESET;
      soft_reset_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ctrl_prev_r <= ctrl_r;
      // Bit 15 arms a one-cycle device reset at the next edge
      soft_reset_r <= ctrl_wr && host_data_in[BIT_SOFT_RESET];
    end
  end

  // One-cycle test pulses from rising edges of the held bits
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clr_err_r <= 1'b0;
      start_test_r <= 1'b0;
    end
    else
    begin
      clr_err_r <= clr_err_rise && !soft_reset_r;
      start_test_r <= start_test_rise && !soft_reset_r;
    end
  end

  assign device_reset = soft_reset_r;
  assign clear_error_count = clr_err_r;
  assign start_error_test = start_test_r;
  assign pattern_generator_reset = ctrl_r[BIT_PAT_RESET];
  assign rx_tx_bypass_bit = ctrl_r[BIT_BYPASS];

  ////////////////////////////////////////////////////////////////////////
  // Host read data; the bus is driven for the cycle after a read strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= '0;
      rd_oe_r <= 1'b0;
    end
    else
    begin
      if (ctrl_rd)
        rdata_r <= ctrl_r;
      else if (win_rd)
        rdata_r <= win_rdata;
      // One cycle of drive only, so the host can turn the bus round at once
      rd_oe_r <= ctrl_rd || win_rd;
    end
  end

  assign host_data_out = rdata_r;
  assign host_data_oe_n = !rd_oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Block programming walker hookup
  assign bi.clr = soft_reset_r;
  assign bi.start = ctrl_wr && bpe_rise;
  assign bi.abort = bpe_host_clear;
  // Full mode is taken from the write itself, so setting it together with the
  // start bit already walks the whole space from channel zero
  assign bi.full = ctrl_wr ? host_data_in[BIT_FULL_BLOCK] : ctrl_r[BIT_FULL_BLOCK];
  assign bi.start_addr = block_start_address;
  assign bi.end_addr = block_end_address;

  tsc_block_walker u_walker
  (
    .clk(clk),
    .reset(reset),
    .bi(bi)
  );

  // Walker writes carry the mode value and low word clear from the register
  assign blk_wr = bi.wr;
  assign blk_all_streams = bi.all_streams;
  assign blk_stream = bi.stream;
  assign blk_channel = bi.channel;
  assign blk_channel_mode_bits = ctrl_r[BPV_HI:BPV_LO];
  assign blk_clear_low_word = ctrl_r[BIT_CLR_LOW];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the drive pin and receive streams
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ode_meta_r <= 1'b0;
      ode_sync_r <= 1'b0;
      rx_meta_r <= '0;
      rx_sync_r <= '0;
    end
    else
    begin
      // Only the second stage is read by the logic
      ode_meta_r <= output_drive_pin;
      ode_sync_r <= ode_meta_r;
      rx_meta_r <= rx_data;
      rx_sync_r <= rx_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive, indication level and transmit selection
  assign drive_on = ode_sync_r || ctrl_r[BIT_STANDBY];
  // Indication level: polarity bit tells which level means driven
  assign ind_level = ctrl_r[BIT_IND_POL] ? drive_on : !drive_on;
  // Bypass trades the switching path for the shortest route
  assign tx_data_sel = ctrl_r[BIT_BYPASS] ? rx_sync_r : switched_data;

  // All-outputs mode puts indication on every pin; rate match is host's job
  assign tx_mux = ctrl_r[BIT_ALL_IND] ? {NUM_STREAMS{ind_level}} : tx_data_sel;

  // Registered transmit data, enables and group indication pins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_r <= '0;
      tx_oe_n_r <= '1;
      ind_r <= '0;
    end
    else
    begin
      tx_r <= tx_mux;
      // All-outputs mode keeps every pin driven so the indication is seen
      tx_oe_n_r <= (ctrl_r[BIT_ALL_IND] || drive_on) ? '0 : '1;
      ind_r <= data_rate_select & {NUM_GROUPS{ind_level}};
    end
  end

  assign tx_out = tx_r;
  // Enables are not gated per group; groups only steer the indication pins
  assign tx_oe_n = tx_oe_n_r;
  assign enable_indication_pin = ind_r;
endmodule : tsc_switch_control

// >>> verif/tsc_switch_control_props.sv
// Concurrent checks on the switch control register ports
`timescale 1ns/10ps
module tsc_ctrl_props
#(
  parameter int NUM_STREAMS = 64,
  parameter int NUM_GROUPS = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host bus
  input wire logic [tsc_pkg::ADDR_W-1:0] host_addr,
  input wire logic [tsc_pkg::CTRL_W-1:0] host_data_in,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [tsc_pkg::CTRL_W-1:0] host_data_out,
  // Window and block port
  input wire logic cm_low_sel,
  input wire logic cm_high_sel,
  input wire logic dm_sel,
  input wire logic [tsc_pkg::CTRL_W-1:0] mem_rdata_cmh,
  input wire logic blk_wr,
  input wire logic blk_all_streams,
  input wire logic [tsc_pkg::CH_W-1:0] blk_channel,
  input wire logic [tsc_pkg::BPV_W-1:0] blk_channel_mode_bits,
  input wire logic blk_clear_low_word,
  // Control outputs
  input wire logic pattern_generator_reset,
  input wire logic clear_error_count,
  input wire logic start_error_test,
  input wire logic device_reset,
  input wire logic [NUM_STREAMS-1:0] tx_oe_n,
  input wire logic rx_tx_bypass_bit
);
  import tsc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Host write aimed at the control register page
  wire ctrl_wr = host_cs && host_wr && (host_addr[PAGE_HI:PAGE_LO] == CTRL_PAGE);
  wire [CTRL_W-1:0] d = host_data_in;
  //////////////////////////////////////////////////////////////////////////////
  // Start of a full walk, then its first two channel rows
  sequence s_full_go;
    ctrl_wr && d[BIT_BLOCK_EN] && d[BIT_FULL_BLOCK] && !blk_wr;
  endsequence
  sequence s_first_rows;
    (blk_wr && blk_all_streams && blk_channel == 9'h000) ##1 (blk_wr && blk_channel == 9'h001);
  endsequence
  property p_full_walk;
    s_full_go |=> s_first_rows;
  endproperty
  a_full_walk: assert property (p_full_walk) else $error("full walk start");
  property p_blk_value;
    s_full_go |=> blk_channel_mode_bits == $past(d[BPV_HI:BPV_LO])
      && blk_clear_low_word == $past(d[BIT_CLR_LOW]);
  endproperty
  a_blk_value: assert property (p_blk_value) else $error("block value");
  property p_soft_reset;
    ctrl_wr && d[BIT_SOFT_RESET] |=> device_reset ##1 !rx_tx_bypass_bit;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset");
  property p_level_bits;
    ctrl_wr |=> rx_tx_bypass_bit == $past(d[BIT_BYPASS])
      && pattern_generator_reset == $past(d[BIT_PAT_RESET]);
  endproperty
  a_level_bits: assert property (p_level_bits) else $error("level bits");
  // Edge pulses come two edges after the write and last one cycle
  property p_clear_pulse;
    clear_error_count |-> $past(ctrl_wr, 2) && $past(d[BIT_CLR_ERR], 2) ##1 !clear_error_count;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse");
  property p_start_pulse;
    start_error_test |-> $past(ctrl_wr, 2) && $past(d[BIT_START_TEST], 2) ##1 !start_error_test;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse");
  property p_win_sel;
    cm_low_sel || cm_high_sel || dm_sel |-> host_addr[WIN_BIT]
      && $onehot({cm_low_sel, cm_high_sel, dm_sel});
  endproperty
  a_win_sel: assert property (p_win_sel) else $error("window select");
  property p_win_read;
    host_cs && host_rd && cm_high_sel |=> host_data_out == $past(mem_rdata_cmh);
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read");
  property p_abort;
    ctrl_wr && !d[BIT_BLOCK_EN] && $past(blk_wr) |=> !blk_wr [*4];
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_blk_hold;
    blk_wr && $past(blk_wr) |-> $stable(blk_channel_mode_bits) && $stable(blk_clear_low_word);
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block value moved");
  property p_standby;
    ctrl_wr && d[BIT_STANDBY] |-> ##[1:3] (tx_oe_n == '0);
  endproperty
  a_standby: assert property (p_standby) else $error("standby drive");
endmodule : tsc_ctrl_props

bind tsc_switch_control tsc_ctrl_props #(.NUM_STREAMS(NUM_STREAMS), .NUM_GROUPS(NUM_GROUPS))
  u_props (.clk, .reset, .host_addr, .host_data_in, .host_cs, .host_wr, .host_rd,
  .host_data_out, .cm_low_sel, .cm_high_sel, .dm_sel, .mem_rdata_cmh, .blk_wr,
  .blk_all_streams, .blk_channel, .blk_channel_mode_bits, .blk_clear_low_word,
  .pattern_generator_reset, .clear_error_count, .start_error_test, .device_reset,
  .tx_oe_n, .rx_tx_bypass_bit);

// >>> verif/tsc_host_model.sv
// Host processor model on the synchronous parallel bus
`timescale 1ns/10ps
module tsc_host_model
(
  // Clock
  input wire logic clk,
  // Bus
  output logic [tsc_pkg::ADDR_W-1:0] host_addr,
  output logic [tsc_pkg::CTRL_W-1:0] host_data_in,
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  input wire logic [tsc_pkg::CTRL_W-1:0] host_data_out,
  input wire logic host_data_oe_n
);
  import tsc_pkg::*;
  initial
  begin
    {host_cs, host_wr, host_rd, host_addr, host_data_in} = '0;
  end
  // One strobe cycle, then the answer cycle, taken at the edge that closes it;
  // released lines show the inverse so stale values never pass
  task automatic cyc(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] v, input logic w,
                     output logic [CTRL_W-1:0] q, output logic ok);
    host_addr = a;
    host_data_in = v;
    host_cs = 1'b1;
    host_wr = w;
    host_rd = !w;
    @(posedge clk);
    #1;
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = ~a;
    host_data_in = ~v;
    @(posedge clk);
    q = host_data_out;
    ok = !host_data_oe_n;
    #1;
  endtask : cyc
  // Bit 15 stays low unless a reset is meant; bit 4 low while walking aborts
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CTRL_W-1:0] v);
    logic [CTRL_W-1:0] q;
    logic ok;
    cyc(a, v, 1'b1, q, ok);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [CTRL_W-1:0] v, output logic ok);
    cyc(a, 16'h0000, 1'b0, v, ok);
  endtask : rd
endmodule : tsc_host_model

// >>> verif/tsc_switch_control_register_tb_top.sv
// Self-checking bench for the switch control register
`timescale 1ns/10ps
module tsc_switch_control_register_tb_top;
  import tsc_pkg::*;
  logic clk, reset, host_cs, host_wr, host_rd, host_data_oe_n, output_drive_pin, blk_wr;
  logic clear_error_count, start_error_test, device_reset, rx_tx_bypass_bit;
  logic pattern_generator_reset;
  logic [ADDR_W-1:0] host_addr, block_start_address, block_end_address;
  logic [CTRL_W-1:0] host_data_in, host_data_out, mem_rdata_cml, mem_rdata_cmh, mem_rdata_dm;
  logic [7:0] data_rate_select, enable_indication_pin;
  logic [63:0] rx_data, switched_data, tx_out, tx_oe_n;
  int miscompares, checked, n_blk, n_clr, n_start, n_rst;
  tsc_host_model host (.clk, .host_addr, .host_data_in, .host_cs, .host_wr, .host_rd,
    .host_data_out, .host_data_oe_n);
  tsc_switch_control dut (.clk, .reset, .host_addr, .host_data_in, .host_cs, .host_wr,
    .host_rd, .host_data_out, .host_data_oe_n, .mem_wr(), .mem_rd(), .mem_addr(),
    .mem_wdata(), .cm_low_sel(), .cm_high_sel(), .dm_sel(), .mem_rdata_cml, .mem_rdata_cmh,
    .mem_rdata_dm, .block_start_address, .block_end_address, .blk_wr, .blk_all_streams(),
    .blk_stream(), .blk_channel(), .blk_channel_mode_bits(), .blk_clear_low_word(),
    .pattern_generator_reset, .clear_error_count, .start_error_test, .device_reset,
    .output_drive_pin, .data_rate_select, .rx_data, .switched_data, .tx_out, .tx_oe_n,
    .enable_indication_pin, .rx_tx_bypass_bit);
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Event counters for pulses and block writes
  always @(posedge clk)
  begin
    n_blk += blk_wr;
    n_clr += clear_error_count;
    n_start += start_error_test;
    n_rst += device_reset;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rdc(input logic [CTRL_W-1:0] e);
    logic [CTRL_W-1:0] v;
    logic ok;
    host.rd(16'h0000, v, ok);
    chk(ok, 1'b1, "read answer");
    chk(v, e, "control readback");
  endtask : rdc
  // Ranged walk: expected count is channels times streams, wrap included
  task automatic t_range(input logic [15:0] sa, input logic [15:0] ea, input int exp);
    block_start_address = sa;
    block_end_address = ea;
    n_blk = 0;
    host.wr(16'h0000, 16'h0050);
    tick(exp + 6);
    chk(n_blk, exp, "ranged count");
    rdc(16'h0000);
  endtask : t_range
  task automatic t_bits;
    chk(tx_oe_n, '1, "float after reset");
    host.wr(16'h0000, 16'h4a0d);
    rdc(16'h4a0d);
    chk({rx_tx_bypass_bit, pattern_generator_reset}, 2'b11, "level bits");
    tick(4);
    chk(tx_oe_n, '0, "standby drive");
    chk(tx_out, rx_data, "bypass data");
    host.wr(16'h0000, 16'h0000);
    tick(4);
    chk(tx_out, switched_data, "switched data");
    chk(tx_oe_n, '1, "float again");
  endtask : t_bits
  task automatic t_edges;
    n_clr = 0;
    n_start = 0;
    host.wr(16'h0000, 16'h0400);
    tick(3);
    chk(n_clr, 1, "clear pulse");
    host.wr(16'h0000, 16'h0400);
    tick(3);
    chk(n_clr, 1, "steady clear");
    host.wr(16'h0000, 16'h0600);
    tick(3);
    chk({n_clr[3:0], n_start[3:0]}, 8'h11, "start pulse");
  endtask : t_edges
  task automatic t_window;
    logic [CTRL_W-1:0] exp_q [4];
    logic [CTRL_W-1:0] v;
    logic ok;
    exp_q = '{mem_rdata_cml, mem_rdata_cmh, mem_rdata_dm, 16'h0000};
    for (int i = 0; i < 4; i++)
    begin
      host.wr(16'h0000, 16'(i));
      host.rd(16'hffff, v, ok);
      chk(v, exp_q[i], "window read");
    end
  endtask : t_window
  task automatic t_blocks;
    n_blk = 0;
    host.wr(16'h0000, 16'h01f8);
    tick(520);
    chk(n_blk, 512, "full rows");
    rdc(16'h0108);
    t_range({4'h2, 3'd1, 9'd5}, {4'hf, 3'd2, 9'd6}, 4);
    t_range({4'h1, 3'd3, 9'd510}, {4'hf, 3'd2, 9'd1}, 32);
    n_blk = 0;
    host.wr(16'h0000, 16'h0110);
    tick(10);
    host.wr(16'h0000, 16'h0100);
    tick(20);
    chk(n_blk > 0 && n_blk < 13, 1'b1, "abort count");
    rdc(16'h0100);
  endtask : t_blocks
  task automatic t_srst;
    n_rst = 0;
    host.wr(16'h0000, 16'hc008);
    tick(3);
    chk(n_rst, 1, "device reset");
    rdc(16'h0000);
  endtask : t_srst
  // Indication level follows drive state through the polarity bit
  task automatic t_drive;
    output_drive_pin = 1'b1;
    tick(4);
    chk(tx_oe_n, '0, "pin drive");
    host.wr(16'h0000, 16'h3000);
    tick(3);
    chk(tx_out, '1, "indicate high");
    chk(enable_indication_pin, 8'h5a, "group level");
    host.wr(16'h0000, 16'h1000);
    tick(3);
    chk(tx_out, '0, "indicate low");
    chk(enable_indication_pin, '0, "group low");
    output_drive_pin = 1'b0;
    tick(4);
    chk(tx_out, '1, "indicate float");
  endtask : t_drive
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    output_drive_pin = 1'b0;
    data_rate_select = 8'h5a;
    block_start_address = '0;
    block_end_address = '0;
    rx_data = 64'h0123_4567_89ab_cdef;
    switched_data = 64'hfedc_ba98_7654_3210;
    mem_rdata_cml = 16'h1c1c;
    mem_rdata_cmh = 16'h2d2d;
    mem_rdata_dm = 16'h3e3e;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    rdc(CTRL_RESET);
    t_bits;
    t_edges;
    t_window;
    t_blocks;
    t_srst;
    t_drive;
    end_sim;
  end
  // Whole run is near 700 cycles; allow about seven times that
  initial
  begin
    #500000;
    miscompares++;
    end_sim;
  end
endmodule : tsc_switch_control_register_tb_top
